//--- hdl/smx_pec.sv
// packet check unit: bitwise crc-8 over every data bit strobed by bit_en
`timescale 1ns/100ps
module smx_pec (
   // clock, reset, enable
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic ce,
   // engine side
   smx_pec_if.calc   pif
);
   logic [7:0] crc;

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? smx_pkg::CRC_POLY : smx_pkg::CRC_ZERO);
   endfunction

   assign pif.crc = crc;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         crc <= smx_pkg::CRC_ZERO;
      else if (ce)
      begin
         if (pif.clear)
            crc <= smx_pkg::CRC_ZERO;
         else if (pif.bit_en)
            crc <= crc_step(crc, pif.bit_val);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst || !ce);

   property p_crc_step;
      (pif.bit_en && !pif.clear) |=> (crc == crc_step($past(crc), $past(pif.bit_val)));
   endproperty
   a_crc_step: assert property (p_crc_step) else $error("crc not stepped by bit");

   property p_crc_clear;
      pif.clear |=> (crc == smx_pkg::CRC_ZERO) && (pif.crc == crc);
   endproperty
   a_crc_clear: assert property (p_crc_clear) else $error("crc not zeroed");
endmodule

//--- hdl/smx_pec_if.sv
// carrier between the pin engine and the packet check unit
`timescale 1ns/100ps
interface smx_pec_if;
   logic       clear;
   logic       bit_en;
   logic       bit_val;
   logic [7:0] crc;
   modport engine (output clear, output bit_en, output bit_val, input crc);
   modport calc   (input clear, input bit_en, input bit_val, output crc);
endinterface

//--- hdl/smx_pkg.sv
// constants, register map and state codes of the smbus slave extension
// Operation
// - a one in smbus_mode_enable selects smbus operation, otherwise plain two-wire slave
// - in smbus operation only seven-bit addresses match, ten-bit matching is off
// - every timeout limit comes from the timeout_config_register loaded by software
// - packet_check_enable turns on automatic check byte handling for the current transfer
// - check generator takes every data bit outside the idle and skip states, enabled or not
// - receiver compares check byte with own value, acks a match, naks a mismatch
// - a check mismatch sets packet_check_error_flag in the status_register
// - transmitter sends its check byte when remaining_byte_count reaches the last byte
// - receiver treats the byte arriving as remaining_byte_count reaches zero as check byte
// - an expired timeout releases the bus and sets bus_timeout_flag
// - writing one to alert_request_bit pulls the alert line low
// - a pending alert request also enables alert response address matching
// - separate control bits enable alert response and host header address matching
// - a one written to interrupt_mask_clear clears that mask bit, zero leaves it
package smx_pkg;
   // register byte offsets
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_TOUT   = 8'h04;
   localparam logic [7:0]  OFF_STAT   = 8'h08;
   localparam logic [7:0]  OFF_MASK   = 8'h0c;
   localparam logic [7:0]  OFF_OADDR  = 8'h10;
   localparam logic [7:0]  OFF_COUNT  = 8'h14;
   localparam logic [7:0]  OFF_TXD    = 8'h18;
   localparam logic [7:0]  OFF_RXD    = 8'h1c;
   localparam logic [7:0]  OFF_IDR    = 8'h20;
   // control_register bits
   localparam int          C_EN       = 0;
   localparam int          C_SMBUS_MODE_ENABLE     = 1;
   localparam int          C_PACKET_CHECK_ENABLE    = 2;
   localparam int          C_ALERT    = 3;
   localparam int          C_ARAEN    = 4;
   localparam int          C_HHEN     = 5;
   localparam int          C_TEN      = 6;
   localparam logic [31:0] CTRL_MASK  = 32'h0000_007f;
   // status_register and interrupt_mask bits
   localparam int          S_RXRDY    = 0;
   localparam int          S_TXRDY    = 1;
   localparam int          S_TCOMP    = 3;
   localparam int          S_NAK      = 8;
   localparam int          S_TOUT     = 12;
   localparam int          S_PECERR   = 13;
   localparam int          S_SAM      = 16;
   localparam int          S_ARAM     = 18;
   localparam int          S_HHM      = 19;
   localparam int          S_STO      = 21;
   localparam logic [31:0] STAT_MASK  = 32'h002d_310b;
   // timeout_config_register fields
   localparam int          TO_LIM_MSB = 15;
   localparam int          TO_PRE_LSB = 16;
   localparam int          TO_PRE_MSB = 23;
   // reset values and protocol constants
   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
   localparam logic [9:0]  RST_OADDR  = 10'h000;
   localparam logic [6:0]  ARA_ADDR   = 7'h0c;
   localparam logic [6:0]  HH_ADDR    = 7'h08;
   localparam logic [4:0]  TEN_HDR    = 5'h1e;
   localparam logic [7:0]  CRC_POLY   = 8'h07;
   localparam logic [7:0]  CRC_ZERO   = 8'h00;
   localparam logic [3:0]  BIT_ACK    = 4'h8;
   localparam logic [3:0]  BIT_FIRST  = 4'h0;
   localparam logic [3:0]  BIT_STEP   = 4'h1;
   // pin engine states
   typedef enum logic [2:0]
   {
      st_idle  = 3'b000,
      st_addr  = 3'b001,
      st_addr2 = 3'b010,
      st_rx    = 3'b011,
      st_tx    = 3'b100,
      st_skip  = 3'b101
   } smx_state_e;
endpackage

//--- hdl/smx_slave.sv
// smbus slave extension: avalon register file, pin engine, timeout and interrupt
`timescale 1ns/100ps
module smx_slave #(
   parameter int CNT_W = 8
)(
   // clock, reset, enable
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        ce,
   // avalon-mm slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             alert_o,
   output logic             alert_oe,
   // interrupt
   output logic             irq
);
   localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
   localparam logic [CNT_W-1:0] CNT_NONE = {CNT_W{1'b0}};

   smx_pkg::smx_state_e st;
   logic [2:0]       scl_s;
   logic [2:0]       sda_s;
   logic             scl_f;
   logic             sda_f;
   logic [3:0]       bitcnt;
   logic             ackph;
   logic [7:0]       shreg;
   logic [7:0]       rx_data;
   logic [7:0]       tx_data;
   logic [9:0]       own_addr;
   logic [CNT_W-1:0] count;
   logic [31:0]      ctrl;
   logic [31:0]      tcfg;
   logic [31:0]      status;
   logic [31:0]      mask;
   logic [31:0]      ev;
   logic [15:0]      tcnt;
   logic [7:0]       pcnt;

   smx_pec_if pec ();

   ////////////////////////////////////////////////////////////////////////////////////
   // pin sampling: a level counts once the second and third stages agree
   wire scl_new   = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
   wire sda_new   = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
   wire scl_rise  = scl_new & ~scl_f;
   wire scl_fall  = ~scl_new & scl_f;
   wire start_det = ~sda_new & sda_f & scl_new & scl_f;
   wire stop_det  = sda_new & ~sda_f & scl_new & scl_f;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
      end
      else if (ce)
      begin
         scl_s <= {scl_s[1:0], scl_i};
         sda_s <= {sda_s[1:0], sda_i};
         scl_f <= scl_new;
         sda_f <= sda_new;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // byte phases and address matching
   wire in_xfer    = (st != smx_pkg::st_idle) && (st != smx_pkg::st_skip);
   wire data_rise  = scl_rise & in_xfer & (bitcnt < smx_pkg::BIT_ACK);
   wire data_fall  = scl_fall & (bitcnt < smx_pkg::BIT_ACK) & (bitcnt != smx_pkg::BIT_FIRST);
   wire byte_fall  = scl_fall & (bitcnt == smx_pkg::BIT_ACK) & ~ackph;
   wire ack_rise   = scl_rise & (bitcnt == smx_pkg::BIT_ACK) & ackph;
   wire ack_fall   = scl_fall & (bitcnt == smx_pkg::BIT_ACK) & ackph;
   wire smb_on     = ctrl[smx_pkg::C_SMBUS_MODE_ENABLE];
   wire ten_on     = ctrl[smx_pkg::C_TEN] & ~smb_on;
   wire [6:0] a7   = shreg[7:1];
   wire ara_en     = ctrl[smx_pkg::C_ALERT] | ctrl[smx_pkg::C_ARAEN];
   wire hit_own    = ~ten_on & (a7 == own_addr[6:0]);
   wire hit_ara    = smb_on & ara_en & (a7 == smx_pkg::ARA_ADDR) & shreg[0];
   wire hit_hh     = smb_on & ctrl[smx_pkg::C_HHEN] & (a7 == smx_pkg::HH_ADDR) & ~shreg[0];
   wire hit_ten1   = ten_on & (shreg[7:3] == smx_pkg::TEN_HDR)
                     & (shreg[2:1] == own_addr[9:8]) & ~shreg[0];
   wire hit_ten2   = (shreg == own_addr[7:0]);
   wire hit_any    = hit_own | hit_ara | hit_hh;

   // packet check: the count includes the check byte, so one left means check byte
   wire pec_on     = ctrl[smx_pkg::C_PACKET_CHECK_ENABLE] & smb_on;
   wire last_byte  = (count == CNT_ONE);
   wire pec_last   = pec_on & last_byte;
   wire pec_ok     = (pec.crc == smx_pkg::CRC_ZERO);
   wire [7:0] tx_next = pec_last ? pec.crc : tx_data;
   wire cnt_dec    = (count != CNT_NONE)
                     & ((byte_fall & (st == smx_pkg::st_rx)) | (ack_fall & (st == smx_pkg::st_tx)));

   assign pec.clear   = start_det & (st == smx_pkg::st_idle);
   assign pec.bit_en  = data_rise;
   assign pec.bit_val = sda_f;

   smx_pec u_pec (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .pif     (pec.calc)
   );

   ////////////////////////////////////////////////////////////////////////////////////
   // clock-low timeout in prescaled ticks; a zero limit disables it
   wire [15:0] t_lim = tcfg[smx_pkg::TO_LIM_MSB:0];
   wire t_run  = smb_on & (st != smx_pkg::st_idle) & ~scl_f;
   wire t_tick = (pcnt == tcfg[smx_pkg::TO_PRE_MSB:smx_pkg::TO_PRE_LSB]);
   wire t_hit  = t_run & t_tick & (tcnt == t_lim) & (t_lim != 16'h0000);

   always_ff @(posedge clk_sys)
   begin
      if (srst | (ce & ~t_run))
      begin
         tcnt <= 16'h0000;
         pcnt <= 8'h00;
      end
      else if (ce)
      begin
         pcnt <= t_tick ? 8'h00 : pcnt + 8'h01;
         tcnt <= t_tick ? tcnt + 16'h0001 : tcnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // pin engine; while enabled, sda changes only while scl is low so no false start or stop
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st      <= smx_pkg::st_idle;
         bitcnt  <= smx_pkg::BIT_FIRST;
         ackph   <= 1'b0;
         shreg   <= 8'h00;
         rx_data <= 8'h00;
         sda_oe  <= 1'b0;
         ev      <= smx_pkg::RST_ZERO;
      end
      else if (ce)
      begin
         ev <= smx_pkg::RST_ZERO;
         if (~ctrl[smx_pkg::C_EN] | t_hit)
         begin
            st     <= smx_pkg::st_idle;
            sda_oe <= 1'b0;
            ev[smx_pkg::S_TOUT] <= t_hit;
         end
         else if (start_det)
         begin
            st     <= smx_pkg::st_addr;
            bitcnt <= smx_pkg::BIT_FIRST;
            ackph  <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (stop_det)
         begin
            st     <= smx_pkg::st_idle;
            sda_oe <= 1'b0;
            ev[smx_pkg::S_STO] <= (st != smx_pkg::st_idle);
         end
         else
         begin
            if (data_rise)
            begin
               shreg  <= {shreg[6:0], sda_f};
               bitcnt <= bitcnt + smx_pkg::BIT_STEP;
            end
            if (data_fall & (st == smx_pkg::st_tx))
               sda_oe <= ~shreg[7];
            if (ack_rise & (st == smx_pkg::st_tx))
            begin
               ev[smx_pkg::S_TCOMP] <= (count == CNT_NONE);
               if (sda_f)
               begin
                  st <= smx_pkg::st_skip;
                  ev[smx_pkg::S_NAK] <= 1'b1;
               end
            end
            if (byte_fall)
            begin
               ackph <= 1'b1;
               case (st)
                  smx_pkg::st_addr:
                  begin
                     sda_oe <= hit_any | hit_ten1;
                     ev[smx_pkg::S_SAM]  <= hit_own;
                     ev[smx_pkg::S_ARAM] <= hit_ara;
                     ev[smx_pkg::S_HHM]  <= hit_hh;
                     if (hit_any)
                        st <= shreg[0] ? smx_pkg::st_tx : smx_pkg::st_rx;
                     else if (hit_ten1)
                        st <= smx_pkg::st_addr2;
                     else
                        st <= smx_pkg::st_skip;
                  end
                  smx_pkg::st_addr2:
                  begin
                     sda_oe <= hit_ten2;
                     ev[smx_pkg::S_SAM] <= hit_ten2;
                     st <= hit_ten2 ? smx_pkg::st_rx : smx_pkg::st_skip;
                  end
                  smx_pkg::st_rx:
                  begin
                     rx_data <= shreg;
                     ev[smx_pkg::S_RXRDY] <= 1'b1;
                     ev[smx_pkg::S_TCOMP] <= last_byte;
                     // check byte: crc over everything including it is zero on a match
                     sda_oe <= ~pec_last | pec_ok;
                     ev[smx_pkg::S_PECERR] <= pec_last & ~pec_ok;
                  end
                  default:
                     sda_oe <= 1'b0;
               endcase
            end
            if (ack_fall)
            begin
               bitcnt <= smx_pkg::BIT_FIRST;
               ackph  <= 1'b0;
               if (st == smx_pkg::st_tx)
               begin
                  shreg  <= tx_next;
                  sda_oe <= ~tx_next[7];
                  ev[smx_pkg::S_TXRDY] <= ~pec_last;
               end
               else
                  sda_oe <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, writes land on the edge after the one that ends the wait
   wire rd       = read & waitrequest;
   wire wr       = write & ~waitrequest;
   wire wr_ctrl  = wr & (address == smx_pkg::OFF_CTRL);
   wire wr_tout  = wr & (address == smx_pkg::OFF_TOUT);
   wire wr_stat  = wr & (address == smx_pkg::OFF_STAT);
   wire wr_mask  = wr & (address == smx_pkg::OFF_MASK);
   wire wr_oaddr = wr & (address == smx_pkg::OFF_OADDR);
   wire wr_count = wr & (address == smx_pkg::OFF_COUNT);
   wire wr_txd   = wr & (address == smx_pkg::OFF_TXD);
   wire wr_idr   = wr & (address == smx_pkg::OFF_IDR);
   wire [31:0] stat_clr = wr_stat ? writedata : smx_pkg::RST_ZERO;
   wire [31:0] rd_val =
      (address == smx_pkg::OFF_CTRL)  ? ctrl :
      (address == smx_pkg::OFF_TOUT)  ? tcfg :
      (address == smx_pkg::OFF_STAT)  ? status :
      (address == smx_pkg::OFF_MASK)  ? mask :
      (address == smx_pkg::OFF_OADDR) ? 32'(own_addr) :
      (address == smx_pkg::OFF_COUNT) ? 32'(count) :
      (address == smx_pkg::OFF_TXD)   ? 32'(tx_data) :
      (address == smx_pkg::OFF_RXD)   ? 32'(rx_data) :
      smx_pkg::RST_ZERO;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         waitrequest <= 1'b1;
         readdata    <= smx_pkg::RST_ZERO;
      end
      else if (ce)
      begin
         waitrequest <= ~((read | write) & waitrequest);
         if (rd)
            readdata <= rd_val;
      end
   end

   // check enable lasts for one transfer: a stop drops it unless software rewrites it
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrl     <= smx_pkg::RST_ZERO;
         tcfg     <= smx_pkg::RST_ZERO;
         own_addr <= smx_pkg::RST_OADDR;
         tx_data  <= 8'h00;
      end
      else if (ce)
      begin
         if (wr_ctrl)
            ctrl <= writedata & smx_pkg::CTRL_MASK;
         else if (ev[smx_pkg::S_STO])
            ctrl[smx_pkg::C_PACKET_CHECK_ENABLE] <= 1'b0;
         if (wr_tout)
            tcfg <= writedata;
         if (wr_oaddr)
            own_addr <= writedata[9:0];
         if (wr_txd)
            tx_data <= writedata[7:0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         count    <= CNT_NONE;
         mask     <= smx_pkg::RST_ZERO;
         status   <= smx_pkg::RST_ZERO;
         irq      <= 1'b0;
         alert_oe <= 1'b0;
         alert_o  <= 1'b0;
         sda_o    <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_count)
            count <= writedata[CNT_W-1:0];
         else if (cnt_dec)
            count <= count - CNT_ONE;
         if (wr_mask)
            mask <= writedata & smx_pkg::STAT_MASK;
         else if (wr_idr)
            mask <= mask & ~writedata;
         status   <= ((status & ~stat_clr) | ev) & smx_pkg::STAT_MASK;
         irq      <= |(status & mask);
         alert_oe <= ctrl[smx_pkg::C_ALERT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst || !ce);

   sequence s_left_bus;
      (st == smx_pkg::st_idle && !sda_oe) ##1 status[smx_pkg::S_TOUT];
   endsequence
   sequence s_addr_byte;
      byte_fall && st == smx_pkg::st_addr;
   endsequence

   property p_timeout;
      t_hit |=> s_left_bus;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not leave bus");

   property p_limit;
      (t_run && t_lim != 16'h0000) |-> (tcnt <= t_lim);
   endproperty
   a_limit: assert property (p_limit) else $error("timeout count passed limit");

   property p_plain_mode;
      (s_addr_byte and (!smb_on && !hit_own && !ten_on && a7 == smx_pkg::ARA_ADDR))
         |=> st == smx_pkg::st_skip && !sda_oe;
   endproperty
   a_plain_mode: assert property (p_plain_mode) else $error("protocol address in plain mode");

   property p_no_ten;
      (s_addr_byte and smb_on) |=> st != smx_pkg::st_addr2;
   endproperty
   a_no_ten: assert property (p_no_ten) else $error("ten-bit match in smbus mode");

   property p_pec_arm;
      (wr_ctrl && writedata[smx_pkg::C_PACKET_CHECK_ENABLE] && writedata[smx_pkg::C_SMBUS_MODE_ENABLE]) |=> pec_on;
   endproperty
   a_pec_arm: assert property (p_pec_arm) else $error("check enable not armed");

   property p_pec_ack;
      (byte_fall && st == smx_pkg::st_rx && pec_last) |=> sda_oe == $past(pec_ok);
   endproperty
   a_pec_ack: assert property (p_pec_ack) else $error("wrong answer to check byte");

   property p_pec_err;
      (byte_fall && st == smx_pkg::st_rx && pec_last && !pec_ok)
         |-> ##2 status[smx_pkg::S_PECERR];
   endproperty
   a_pec_err: assert property (p_pec_err) else $error("check error flag not set");

   property p_pec_tx;
      (ack_fall && st == smx_pkg::st_tx && pec_last) |=> shreg == $past(pec.crc);
   endproperty
   a_pec_tx: assert property (p_pec_tx) else $error("check byte not inserted");

   property p_data_ack;
      (byte_fall && st == smx_pkg::st_rx && !pec_last) |=> sda_oe;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data byte not acked");

   property p_alert;
      ctrl[smx_pkg::C_ALERT] |=> alert_oe && !alert_o;
   endproperty
   a_alert: assert property (p_alert) else $error("alert line not pulled");

   property p_ara;
      (s_addr_byte and (smb_on && ctrl[smx_pkg::C_ALERT] && a7 == smx_pkg::ARA_ADDR && shreg[0]))
         |=> st == smx_pkg::st_tx && sda_oe;
   endproperty
   a_ara: assert property (p_ara) else $error("alert response address ignored");

   property p_hh_off;
      (s_addr_byte and (!ctrl[smx_pkg::C_HHEN] && a7 == smx_pkg::HH_ADDR && !hit_own))
         |=> !sda_oe;
   endproperty
   a_hh_off: assert property (p_hh_off) else $error("host header matched while off");

   property p_idr;
      wr_idr |=> ((mask & $past(writedata)) == smx_pkg::RST_ZERO)
                 && ((mask | $past(writedata)) == ($past(mask) | $past(writedata)));
   endproperty
   a_idr: assert property (p_idr) else $error("mask clear wrong");
endmodule

//--- test/smx_bus_master.sv
// smbus master model driving the bus clock and the data line
`timescale 1ns/100ps
module smx_bus_master (
   // clock and line levels
   input  wire logic clk_sys,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda
);
   // bus clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // one bit: 320 ns period; low for 200 ns so a slave answer lands before scl rises
   task automatic put(input logic b, output logic r);
      sda <= b;
      hold(5);
      scl <= 1'b1;
      hold(2);
      r = sda_in;
      hold(1);
      scl <= 1'b0;
   endtask
   task automatic start;
      sda <= 1'b0;
      hold(4);
      scl <= 1'b0;
   endtask
   task automatic stop;
      sda <= 1'b0;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda <= 1'b1;
      hold(4);
   endtask
   // released line reads the pull-up during the ack slot
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put(b[i], r);
      put(1'b1, ack);
   endtask
   // master receiver: line released for the data bits, ack bit given by the caller
   task automatic recv(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         put(1'b1, r);
         b[i] = r;
      end
      put(ack, r);
   endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the smbus slave extension
`timescale 1ns/100ps
module tb_top;
   logic        clk_sys;
   logic        srst;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        scl;
   logic        sda_m;
   logic        sda_oe;
   logic        alert_oe;
   logic        sda_o;
   logic        alert_o;
   logic        irq;
   logic [31:0] q;
   int          errors;
   int          checked;
   // open-drain data line with pull-up
   wire         sda_w = sda_m & ~sda_oe;
   smx_slave u_smx_slave (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .alert_o(alert_o), .alert_oe(alert_oe), .irq(irq));
   smx_bus_master u_smx_bus_master (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl), .sda(sda_m));
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      address   <= a;
      writedata <= d;
      read      <= ~w;
      write     <= w;
      do
      begin
         @(posedge clk_sys);
         if (++n > 50)
         begin
            errors++;
            test_done();
         end
      end
      while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      c = c ^ b;
      repeat (8) c = c[7] ? ((c << 1) ^ smx_pkg::CRC_POLY) : (c << 1);
      return c;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      bus(1'b0, smx_pkg::OFF_IDR, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, smx_pkg::OFF_MASK, 32'h0000_3000);
      bus(1'b1, smx_pkg::OFF_IDR, 32'h0000_2000);
      bus(1'b0, smx_pkg::OFF_MASK, 32'h0);
      chk(q, 32'h0000_1000);
   endtask
   task automatic t_alert;
      bus(1'b1, smx_pkg::OFF_CTRL, 32'h0000_0008);
      repeat (2) @(posedge clk_sys);
      chk(alert_oe, 1'b1);
      chk({sda_o, alert_o}, 2'b00);
      bus(1'b1, smx_pkg::OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk(alert_oe, 1'b0);
   endtask
   // scl held low past a small limit; mask keeps only the timeout bit
   task automatic t_tout;
      bus(1'b1, smx_pkg::OFF_CTRL, 32'h3);
      bus(1'b1, smx_pkg::OFF_TOUT, 32'h4);
      u_smx_bus_master.start();
      repeat (40) @(posedge clk_sys);
      bus(1'b0, smx_pkg::OFF_STAT, 32'h0);
      chk(q[12], 1'b1);
      chk(sda_oe, 1'b0);
      chk(irq, 1'b1);
      bus(1'b1, smx_pkg::OFF_STAT, 32'h0000_1000);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0);
      u_smx_bus_master.stop();
      bus(1'b1, smx_pkg::OFF_TOUT, 32'h40);
   endtask
   // slave transmitter: one data byte then its own check byte
   task automatic t_pec_tx;
      logic       ack;
      logic [7:0] d;
      bus(1'b1, smx_pkg::OFF_TXD, 32'ha5);
      bus(1'b1, smx_pkg::OFF_COUNT, 32'h2);
      bus(1'b1, smx_pkg::OFF_CTRL, 32'h7);
      u_smx_bus_master.start();
      u_smx_bus_master.send(8'h75, ack);
      chk(ack, 1'b0);
      u_smx_bus_master.recv(1'b0, d);
      chk(d, 8'ha5);
      u_smx_bus_master.recv(1'b1, d);
      chk(d, crc8(crc8(8'h00, 8'h75), 8'ha5));
      u_smx_bus_master.stop();
   endtask
   // protocol addresses: ignored in plain mode, answered per control bits in smbus mode
   task automatic t_ara;
      logic ack;
      bus(1'b1, smx_pkg::OFF_TXD, 32'hff);
      bus(1'b1, smx_pkg::OFF_CTRL, 32'h1);
      u_smx_bus_master.start();
      u_smx_bus_master.send({smx_pkg::ARA_ADDR, 1'b1}, ack);
      chk(ack, 1'b1);
      u_smx_bus_master.stop();
      bus(1'b1, smx_pkg::OFF_CTRL, 32'hb);
      u_smx_bus_master.start();
      u_smx_bus_master.send({smx_pkg::HH_ADDR, 1'b0}, ack);
      chk(ack, 1'b1);
      u_smx_bus_master.stop();
      u_smx_bus_master.start();
      u_smx_bus_master.send({smx_pkg::ARA_ADDR, 1'b1}, ack);
      chk(ack, 1'b0);
      u_smx_bus_master.stop();
      bus(1'b0, smx_pkg::OFF_STAT, 32'h0);
      chk(q[18], 1'b1);
   endtask
   task automatic t_pec(input logic bad);
      logic       ack;
      logic [7:0] c;
      c = crc8(crc8(8'h00, 8'h74), 8'h5a) ^ {7'h0, bad};
      bus(1'b1, smx_pkg::OFF_OADDR, 32'h3a);
      bus(1'b1, smx_pkg::OFF_COUNT, 32'h2);
      bus(1'b1, smx_pkg::OFF_CTRL, 32'h7);
      u_smx_bus_master.start();
      u_smx_bus_master.send(8'h74, ack);
      chk(ack, 1'b0);
      u_smx_bus_master.send(8'h5a, ack);
      chk(ack, 1'b0);
      u_smx_bus_master.send(c, ack);
      chk(ack, bad);
      u_smx_bus_master.stop();
      bus(1'b0, smx_pkg::OFF_STAT, 32'h0);
      chk(q[13], bad);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial
   begin
      srst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      errors = 0;
      checked = 0;
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs();
      t_alert();
      t_tout();
      t_pec(1'b0);
      t_pec(1'b1);
      t_pec_tx();
      t_ara();
      test_done();
   end
endmodule
